// >>> rtl/spci_pkg.sv
// Package: register map, field layout and carrier types for port command issue
`default_nettype none
package spci_pkg;

    // ========================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_ERR_RECOVERED = 8'h30;
    localparam logic [7:0] OFF_QUEUED_ACTIVE = 8'h34;
    localparam logic [7:0] OFF_COMMAND_ISSUE = 8'h38;
    localparam logic [7:0] OFF_PORT_CONTROL = 8'h3c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h44;

    // ========================================
    // Field positions
    localparam int ERR_RECOV_DATA_BIT = 0;
    localparam int ERR_RECOV_COMM_BIT = 1;
    localparam int CTRL_RUN_BIT = 0;
    localparam int IRQ_TAG_DONE_BIT = 0;
    localparam int IRQ_SLOT_DONE_BIT = 1;
    localparam int IRQ_RECOV_COMM_BIT = 2;
    localparam int IRQ_RECOV_DATA_BIT = 3;
    localparam int IRQ_WIDTH = 4;

    // ========================================
    // Reset values
    localparam logic [31:0] RST_QUEUED_ACTIVE = 32'h0000_0000;
    localparam logic [31:0] RST_COMMAND_ISSUE = 32'h0000_0000;
    localparam logic [1:0] RST_ERR_RECOVERED = 2'h0;
    localparam logic [3:0] RST_IRQ = 4'h0;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // ========================================
    // Carrier types
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } spci_bus_req_type;

    // Received frame event from the transport layer
    typedef struct packed {
        logic sdb_valid;        // Set Device Bits frame, successful
        logic [31:0] sdb_sactive;
        logic reg_clear_valid;  // Frame clearing BSY, DRQ and ERR
        logic [4:0] reg_clear_slot;
    } spci_frame_type;

endpackage
`default_nettype wire

// >>> rtl/spci_sync.sv
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module spci_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Level
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;

    // ========================================
    // First stage is read only by the second
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// >>> rtl/spci_rise.sv
// Rising-edge detector producing a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module spci_rise (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Level in, pulse out
    input wire logic level,
    output logic pulse
);

    logic prev_q;

    // ========================================
    // Remember last level; starts high so a level already high at
    // reset release gives no false edge
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= level;
        end
    end

    assign pulse = level & ~prev_q;

endmodule
`default_nettype wire

// >>> rtl/spci_port_cmd.sv
// Port command issue and queued-tag tracking with recovered-error bits
`timescale 1ns/10ps
`default_nettype none
module spci_port_cmd #(
    parameter int SLOTS = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Received frames, same clock as the transport layer
    input wire spci_pkg::spci_frame_type frame,
    // Link-side indications
    input wire logic phy_not_ready,
    input wire logic recovered_data_err,
    input wire logic comreset_seen,
    input wire logic drive_soft_reset,
    // Command engine view
    output logic [31:0] issued_slot_bits,
    output logic [31:0] outstanding_tag_bits,
    output logic port_run_control,
    // Interrupt
    output logic irq
);

    // ========================================
    // Declarations
    spci_pkg::spci_bus_req_type req;
    logic [SLOTS-1:0] tags_q;
    logic [SLOTS-1:0] slots_q;
    logic run_q;
    logic run_stop;
    logic [1:0] err_q;
    logic [spci_pkg::IRQ_WIDTH-1:0] irq_stat_q;
    logic [spci_pkg::IRQ_WIDTH-1:0] irq_mask_q;
    logic [spci_pkg::IRQ_WIDTH-1:0] irq_event;
    logic [31:0] rdata_q;
    logic phy_not_ready_s;
    logic phy_ready_rise;
    logic link_lost_q;
    logic comm_recovered;
    logic [SLOTS-1:0] tag_clear;
    logic [SLOTS-1:0] slot_clear;
    logic wr_tags;
    logic wr_slots;
    logic wr_ctrl;
    logic wr_err;
    logic wr_mask;
    logic rd_err;
    logic rd_irq;

    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    // ========================================
    // Write and read decode
    assign wr_tags = req.wr && req.addr == spci_pkg::OFF_QUEUED_ACTIVE;
    assign wr_slots = req.wr && req.addr == spci_pkg::OFF_COMMAND_ISSUE;
    assign wr_ctrl = req.wr && req.addr == spci_pkg::OFF_PORT_CONTROL;
    assign wr_err = req.wr && req.addr == spci_pkg::OFF_ERR_RECOVERED;
    assign wr_mask = req.wr && req.addr == spci_pkg::OFF_IRQ_MASK;
    assign rd_err = req.rd && req.addr == spci_pkg::OFF_ERR_RECOVERED;
    assign rd_irq = req.rd && req.addr == spci_pkg::OFF_IRQ_STATUS;

    // ========================================
    // Link-side readiness comes from another domain
    spci_sync u_sync_phy (
        .mclk(mclk),
        .reset(reset),
        .async_in(phy_not_ready),
        .sync_out(phy_not_ready_s)
    );

    // Return of readiness after a loss
    spci_rise u_rise_ready (
        .mclk(mclk),
        .reset(reset),
        .level(~phy_not_ready_s),
        .pulse(phy_ready_rise)
    );

    // ========================================
    // Run control; clearing it aborts every slot and tag
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            run_q <= 1'b0;
        end else if (wr_ctrl) begin
            run_q <= req.wdata[spci_pkg::CTRL_RUN_BIT];
        end
    end

    // Only a one-to-zero write counts, not a zero written over zero
    assign run_stop = wr_ctrl && run_q
        && !req.wdata[spci_pkg::CTRL_RUN_BIT];

    // ========================================
    // Completion clears from received frames
    // The transport only flags sdb_valid for successful completions, so
    // failed tags stay set for software recovery
    assign tag_clear = frame.sdb_valid
        ? frame.sdb_sactive[SLOTS-1:0] : '0;

    always_comb begin
        slot_clear = '0;
        if (frame.reg_clear_valid) begin
            slot_clear[frame.reg_clear_slot] = 1'b1;
        end
    end

    // ========================================
    // Queued-active tags; link and drive resets do not touch them
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tags_q <= spci_pkg::RST_QUEUED_ACTIVE[SLOTS-1:0];
        end else if (run_stop) begin
            tags_q <= '0;
        end else begin
            // Software set wins over a same-cycle completion clear
            tags_q <= (tags_q & ~tag_clear)
                | (wr_tags ? req.wdata[SLOTS-1:0] : '0);
        end
    end

    // ========================================
    // Command-issue slots
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            slots_q <= spci_pkg::RST_COMMAND_ISSUE[SLOTS-1:0];
        end else if (run_stop) begin
            slots_q <= '0;
        end else begin
            slots_q <= (slots_q & ~slot_clear)
                | (wr_slots ? req.wdata[SLOTS-1:0] : '0);
        end
    end

    // ========================================
    // Recovered communications: remember a loss until readiness returns
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            link_lost_q <= 1'b0;
        end else if (phy_not_ready_s) begin
            link_lost_q <= 1'b1;
        end else if (phy_ready_rise) begin
            link_lost_q <= 1'b0;
        end
    end

    // A loss seen before reset or power-up does not count as recovered
    assign comm_recovered = phy_ready_rise & link_lost_q;

    // ========================================
    // Recovered error bits, write one to clear, set wins
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            err_q <= spci_pkg::RST_ERR_RECOVERED;
        end else begin
            err_q[spci_pkg::ERR_RECOV_COMM_BIT] <= comm_recovered
                | (err_q[spci_pkg::ERR_RECOV_COMM_BIT]
                & ~(wr_err & req.wdata[spci_pkg::ERR_RECOV_COMM_BIT]));
            err_q[spci_pkg::ERR_RECOV_DATA_BIT] <= recovered_data_err
                | (err_q[spci_pkg::ERR_RECOV_DATA_BIT]
                & ~(wr_err & req.wdata[spci_pkg::ERR_RECOV_DATA_BIT]));
        end
    end

    // ========================================
    // Interrupt events
    always_comb begin
        irq_event = '0;
        irq_event[spci_pkg::IRQ_TAG_DONE_BIT] = |(tags_q & tag_clear);
        irq_event[spci_pkg::IRQ_SLOT_DONE_BIT] = |(slots_q & slot_clear);
        irq_event[spci_pkg::IRQ_RECOV_COMM_BIT] = comm_recovered;
        irq_event[spci_pkg::IRQ_RECOV_DATA_BIT] = recovered_data_err;
    end

    // Sticky status, read clears, new event wins
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= spci_pkg::RST_IRQ;
        end else begin
            irq_stat_q <= irq_event | (rd_irq ? '0 : irq_stat_q);
        end
    end

    // Mask: a one enables the bit onto irq
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_mask_q <= spci_pkg::RST_IRQ;
        end else if (wr_mask) begin
            irq_mask_q <= req.wdata[spci_pkg::IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ========================================
    // Read data, valid in the cycle after the strobe only
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdata_q <= spci_pkg::READ_UNMAPPED;
        end else if (req.rd) begin
            case (req.addr)
                spci_pkg::OFF_QUEUED_ACTIVE: begin
                    rdata_q <= 32'(tags_q);
                end
                spci_pkg::OFF_COMMAND_ISSUE: begin
                    rdata_q <= 32'(slots_q);
                end
                spci_pkg::OFF_PORT_CONTROL: begin
                    rdata_q <= {31'h0000_0000, run_q};
                end
                spci_pkg::OFF_ERR_RECOVERED: begin
                    rdata_q <= {30'h0000_0000, err_q};
                end
                spci_pkg::OFF_IRQ_STATUS: begin
                    rdata_q <= 32'(irq_stat_q);
                end
                spci_pkg::OFF_IRQ_MASK: begin
                    rdata_q <= 32'(irq_mask_q);
                end
                default: begin
                    rdata_q <= spci_pkg::READ_UNMAPPED;
                end
            endcase
        end else begin
            rdata_q <= spci_pkg::READ_UNMAPPED;
        end
    end

    assign reg_rdata = rdata_q;

    // ========================================
    // Command engine view: set slots are ready to send
    assign issued_slot_bits = 32'(slots_q);
    assign outstanding_tag_bits = 32'(tags_q);
    assign port_run_control = run_q;

    // Link and drive resets are noted but deliberately change nothing
    logic unused_resets;
    assign unused_resets = comreset_seen ^ drive_soft_reset
        ^ rd_err;

endmodule
`default_nettype wire

// >>> dv/spci_port_cmd_props.sv
// Checker: timing relations of the port command issue block
`timescale 1ns/10ps
`default_nettype none
module spci_port_cmd_props #(
    parameter int SLOTS = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Frames and tracking outputs
    input wire spci_pkg::spci_frame_type frame,
    input wire logic [31:0] issued_slot_bits,
    input wire logic [31:0] outstanding_tag_bits,
    input wire logic port_run_control,
    input wire logic irq
);
    // ========================================
    // One clock domain, so defaults serve every property
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_sdb_clears_tags: assert property (frame.sdb_valid && !reg_wr |=>
        outstanding_tag_bits == ($past(outstanding_tag_bits) &
        ~$past(frame.sdb_sactive))) else $error("tags not cleared by frame");
    a_frame_clears_slot: assert property (frame.reg_clear_valid &&
        !reg_wr |=> !issued_slot_bits[$past(frame.reg_clear_slot)])
        else $error("slot bit not cleared by frame");
    a_tag_write_sets: assert property (reg_wr && !frame.sdb_valid &&
        reg_addr == spci_pkg::OFF_QUEUED_ACTIVE |=> outstanding_tag_bits ==
        ($past(outstanding_tag_bits) | $past(reg_wdata)))
        else $error("tag write one to set failed");
    a_slot_write_sets: assert property (reg_wr &&
        !frame.reg_clear_valid && reg_addr == spci_pkg::OFF_COMMAND_ISSUE |=>
        issued_slot_bits == ($past(issued_slot_bits) | $past(reg_wdata)))
        else $error("slot write one to set failed");
    a_run_fall_clears: assert property (reg_wr && port_run_control &&
        reg_addr == spci_pkg::OFF_PORT_CONTROL && !reg_wdata[0] |=>
        outstanding_tag_bits == 0 && issued_slot_bits == 0)
        else $error("run stop did not clear tracking bits");
    a_bits_hold_idle: assert property (!reg_wr && !frame.sdb_valid &&
        !frame.reg_clear_valid |=> $stable(outstanding_tag_bits) &&
        $stable(issued_slot_bits))
        else $error("tracking bits moved when idle");
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 0)
        else $error("read data not zero outside a read");
    a_read_slots: assert property (reg_rd &&
        reg_addr == spci_pkg::OFF_COMMAND_ISSUE |=>
        reg_rdata == $past(issued_slot_bits)) else $error("slot read wrong");

    // Main scenarios reached
    c_sdb: cover property (frame.sdb_valid);
    c_stop: cover property (reg_wr && port_run_control && !reg_wdata[0]
        && reg_addr == spci_pkg::OFF_PORT_CONTROL);
    c_set_wins: cover property (reg_wr && frame.sdb_valid
        && reg_addr == spci_pkg::OFF_QUEUED_ACTIVE);
    c_irq: cover property ($rose(irq));
endmodule
bind spci_port_cmd spci_port_cmd_props #(.SLOTS(SLOTS)) u_props (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame(frame),
    .issued_slot_bits(issued_slot_bits), .irq(irq),
    .outstanding_tag_bits(outstanding_tag_bits),
    .port_run_control(port_run_control));
`default_nettype wire

// >>> dv/spci_drive_model.sv
// Behavioural drive side: completion frames and link indications
`timescale 1ns/10ps
`default_nettype none
module spci_drive_model (
    // Clock
    input wire logic mclk,
    // Toward the port
    output var spci_pkg::spci_frame_type frame,
    output var logic phy_not_ready,
    output var logic recovered_data_err,
    output var logic comreset_seen,
    output var logic drive_soft_reset
);
    // ========================================
    // Idle levels at time zero
    initial begin
        frame = '0;
        phy_not_ready = 1'b0;
        recovered_data_err = 1'b0;
        comreset_seen = 1'b0;
        drive_soft_reset = 1'b0;
    end

    // Only successful completions are sent; failed tags stay outstanding
    task automatic sdb(input logic [31:0] tags);
        @(posedge mclk);
        frame.sdb_valid <= 1'b1;
        frame.sdb_sactive <= tags;
        @(posedge mclk);
        frame.sdb_valid <= 1'b0;
        frame.sdb_sactive <= ~tags; // Stale field shows junk, not old value
    endtask

    // Frame leaving BSY, DRQ and ERR clear for one slot
    task automatic clr(input logic [4:0] s);
        @(posedge mclk);
        frame.reg_clear_valid <= 1'b1;
        frame.reg_clear_slot <= s;
        @(posedge mclk);
        frame.reg_clear_valid <= 1'b0;
        frame.reg_clear_slot <= ~s;
    endtask

    // Recovered integrity error, one cycle
    task automatic derr;
        @(posedge mclk);
        recovered_data_err <= 1'b1;
        @(posedge mclk);
        recovered_data_err <= 1'b0;
    endtask

    // Link lost for a few cycles, then back
    task automatic phy_blip;
        @(posedge mclk);
        phy_not_ready <= 1'b1;
        repeat (4) @(posedge mclk);
        phy_not_ready <= 1'b0;
    endtask

    // Link and drive resets together
    task automatic resets;
        @(posedge mclk);
        comreset_seen <= 1'b1;
        drive_soft_reset <= 1'b1;
        @(posedge mclk);
        comreset_seen <= 1'b0;
        drive_soft_reset <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> dv/sata_port_command_issue_bench.sv
// Self-checking bench for port command issue tracking
`timescale 1ns/10ps
`default_nettype none
module sata_port_command_issue_bench;
    // ========================================
    // Signals and reference model
    localparam logic [7:0] QA = spci_pkg::OFF_QUEUED_ACTIVE;
    localparam logic [7:0] SL = spci_pkg::OFF_COMMAND_ISSUE;
    localparam logic [7:0] ER = spci_pkg::OFF_ERR_RECOVERED;
    localparam logic [7:0] SR = spci_pkg::OFF_IRQ_STATUS;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata, slots, tags, rv, rv2, st_m;
    logic [31:0] sa_m = 32'h0000_0000;
    logic [31:0] ci_m = 32'h0000_0000;
    logic pnr, derr, comr, dsr, run, irq;
    spci_pkg::spci_frame_type frame;
    int bad_count = 0;
    int n_checks = 0;
    int seed = 30754;
    int cyc = 0;

    spci_drive_model drv (.mclk(mclk), .frame(frame), .phy_not_ready(pnr),
        .recovered_data_err(derr), .comreset_seen(comr),
        .drive_soft_reset(dsr));
    spci_port_cmd #(.SLOTS(32)) uut (.mclk(mclk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame(frame),
        .phy_not_ready(pnr), .recovered_data_err(derr), .comreset_seen(comr),
        .drive_soft_reset(dsr), .issued_slot_bits(slots),
        .outstanding_tag_bits(tags), .port_run_control(run), .irq(irq));

    // Clock, and a ceiling well above the roughly 140 cycles used
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            tally_and_finish;
        end
    end

    // ========================================
    // Bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        // Unmapped write must not land anywhere
        wr(8'h7c, 32'hffff_ffff);
        rdc(QA, 32'h0000_0000);
        rdc(SL, 32'h0000_0000);
        rdc(8'h7c, 32'h0000_0000);
        rdc(spci_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        wr(spci_pkg::OFF_PORT_CONTROL, 32'h0000_0001);
        rdc(spci_pkg::OFF_PORT_CONTROL, 32'h0000_0001);
        chk({31'h0, run}, 32'h0000_0001);
        $display("test reset done");
        // Tag before slot; edge bits first, then random words
        for (int i = 0; i < 6; i++) begin
            rv = (i == 0) ? 32'h8000_0001 : $random(seed);
            wr(QA, rv);
            sa_m |= rv;
            wr(SL, rv);
            ci_m |= rv;
            rdc(QA, sa_m);
            rdc(SL, ci_m);
        end
        wr(QA, 32'h0000_0000);
        rdc(QA, sa_m);
        $display("test write one to set done");
        // Expected done events come from the model before it changes
        rv = $random(seed);
        st_m = 32'h0000_0000;
        st_m[spci_pkg::IRQ_TAG_DONE_BIT] = |(sa_m & rv);
        st_m[spci_pkg::IRQ_SLOT_DONE_BIT] = ci_m[31] | ci_m[0];
        drv.sdb(rv);
        sa_m &= ~rv;
        drv.clr(5'd31);
        drv.clr(5'd0);
        ci_m &= 32'h7fff_fffe;
        drv.resets();
        settle();
        chk(tags, sa_m);
        chk(slots, ci_m);
        // Completion clear and software set in one cycle: the set wins
        rv = $random(seed);
        rv2 = $random(seed);
        st_m[spci_pkg::IRQ_TAG_DONE_BIT] |= |(sa_m & rv);
        fork
            drv.sdb(rv);
            wr(QA, rv2);
        join
        sa_m = (sa_m & ~rv) | rv2;
        settle();
        chk(tags, sa_m);
        $display("test frames done");
        // Interrupt masked, then unmasked, then cleared by the read
        rdc(SR, st_m);
        wr(spci_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        drv.derr();
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        wr(spci_pkg::OFF_IRQ_MASK, 32'h0000_000f);
        rdc(spci_pkg::OFF_IRQ_MASK, 32'h0000_000f);
        chk({31'h0, irq}, 32'h0000_0001);
        rdc(SR, 32'h0000_0008);
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        rdc(ER, 32'h0000_0001);
        wr(ER, 32'h0000_0001);
        drv.phy_blip();
        repeat (6) @(posedge mclk);
        rdc(ER, 32'h0000_0002);
        rdc(SR, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test errors done");
        wr(spci_pkg::OFF_PORT_CONTROL, 32'h0000_0000);
        settle();
        chk(tags, 32'h0000_0000);
        chk(slots, 32'h0000_0000);
        chk({31'h0, run}, 32'h0000_0000);
        $display("test run stop done");
        // Host reset in mid-run returns every register to zero
        wr(spci_pkg::OFF_PORT_CONTROL, 32'h0000_0001);
        wr(QA, 32'h0000_00f0);
        wr(SL, 32'h0000_00f0);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rdc(QA, 32'h0000_0000);
        rdc(SL, 32'h0000_0000);
        chk({31'h0, run}, 32'h0000_0000);
        $display("test mid-run reset done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
